// File: rtl/tmrcc_defines.svh
// Offsets, field positions, reset values and timing counts of the timer core
`ifndef TMRCC_DEFINES_SVH
`define TMRCC_DEFINES_SVH

`define TMRCC_OFF_SC 12'h000
`define TMRCC_OFF_CNT 12'h004
`define TMRCC_OFF_MOD 12'h008
`define TMRCC_OFF_CH 12'h00C

`define TMRCC_SC_FLAG 7
`define TMRCC_SC_IRQEN 6
`define TMRCC_SC_CALIGN 5
`define TMRCC_SC_CLKS_HI 4
`define TMRCC_SC_CLKS_LO 3
`define TMRCC_SC_PS_HI 2
`define TMRCC_SC_PS_LO 0

`define TMRCC_SC_RESET 8'h00
`define TMRCC_CNT_RESET 16'h0000
`define TMRCC_MOD_RESET 16'h0000
`define TMRCC_CH_RESET 4'h0
`define TMRCC_MOD_FULL 16'hFFFF

`define TMRCC_CLK_PERIOD_NS 20
`define TMRCC_SYNC_STAGES 2

`endif

// File: rtl/tmrcc_pkg.sv
// Types shared by the timer core
package tmrcc_pkg;
    typedef enum logic [1:0] {
        TMRCC_CLK_NONE = 2'b00,
        TMRCC_CLK_BUS = 2'b01,
        TMRCC_CLK_FIXED = 2'b10,
        TMRCC_CLK_EXT = 2'b11
    } tmrcc_clk_src_t;

    typedef enum logic [1:0] {
        TMRCC_DIR_UP = 2'b00,
        TMRCC_DIR_DOWN = 2'b01
    } tmrcc_dir_t;
endpackage

// File: rtl/tmrcc_core.sv
// Timer counter core: clock select, synchroniser, prescaler, overflow, APB
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
`include "tmrcc_defines.svh"
`default_nettype none

// Notes on behaviour
// - Sixteen-bit counter: free, modulo, or up/down in center-aligned mode.
// - Modulo of 0x0000 or 0xFFFF gives a full-range free counter.
// - Counter reads are always allowed and never disturb counting.
// - Any write to the counter resets it, whatever the data.
// - After reset the timer is off; pins are GPIO inputs, no pull-ups.
// - Clock source 1:1 drives the prescaler from the external pin.
// - External clock is synchronised; keep it at or below bus/4.
// - While the timer owns a pin, port data and direction have no effect.
// - Channels needing no pin function hand the pin back to GPIO.
// - Up mode: overflow flag bit 7 sets when counter wraps to 0x0000.
// - Center mode: flag sets when counter turns down from the modulo.
// - Clear flag by reading it set, then writing 0; writing 1 does nothing.
// - An overflow between read and clearing write re-arms the sequence.
// - Interrupt request equals flag AND enable bit 6.
// - Bit 5 selects center-aligned mode; all channels then run centered.
// - Reset clears flag, enable and center select; up-counting mode.
// - Bits 4:3 disable or choose clock; fixed and external are synchronised.
// - Prescale bits 2:0 divide the selected clock by 1 to 128.
// - Channels, timed by the shared counter, choose their own modes.
// - Clock codes: 0:0 none, 0:1 bus, 1:0 fixed, 1:1 external.
// - Prescale code n divides by two to the power n.
// - At the modulo the counter restarts at zero, or turns down if centered.
module tmrcc_core #(
    parameter int CNT_W = 16,
    parameter int PS_W = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_timer_clock_in,
    input wire logic fixed_system_clock,
    input wire logic [1:0] channel_mode_select,
    input wire logic [1:0] channel_edge_level_select,
    input wire logic channel_out,
    input wire logic channel_oe,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    output logic channel_pin_o,
    output logic channel_pin_oe,
    output logic channel_pin_pullup,
    output logic timer_owns_pin,
    output logic [CNT_W-1:0] counter_value,
    output logic center_aligned_pwm,
    output logic overflow_irq
);
    logic [7:0] timer_status_control;
    logic [CNT_W-1:0] modulo_limit;
    logic [3:0] pin_ctrl;
    logic overflow_flag;
    logic clear_armed;
    logic [1:0] ext_sync;
    logic [1:0] fix_sync;
    logic ext_last;
    logic fix_last;
    logic [PS_W-1:0] ps_count;
    tmrcc_pkg::tmrcc_dir_t dir;

    wire logic overflow_irq_enable = timer_status_control[`TMRCC_SC_IRQEN];
    wire logic center_align_select = timer_status_control[`TMRCC_SC_CALIGN];
    wire logic [1:0] clock_source_select =
        timer_status_control[`TMRCC_SC_CLKS_HI:`TMRCC_SC_CLKS_LO];
    wire logic [2:0] prescale_select =
        timer_status_control[`TMRCC_SC_PS_HI:`TMRCC_SC_PS_LO];

    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic rd = acc && !pwrite;
    wire logic sel_sc = paddr == `TMRCC_OFF_SC;
    wire logic sel_cnt = paddr == `TMRCC_OFF_CNT;
    wire logic sel_mod = paddr == `TMRCC_OFF_MOD;
    wire logic sel_ch = paddr == `TMRCC_OFF_CH;
    wire logic mapped = sel_sc || sel_cnt || sel_mod || sel_ch;

    function automatic logic [PS_W-1:0] ps_mask(input logic [2:0] code);
        ps_mask = PS_W'((8'h01 << code) - 8'h01);
    endfunction

    // Synchronisers; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync <= 2'b00;
            fix_sync <= 2'b00;
            ext_last <= 1'b0;
            fix_last <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[0], external_timer_clock_in};
            fix_sync <= {fix_sync[0], fixed_system_clock};
            ext_last <= ext_sync[1];
            fix_last <= fix_sync[1];
        end
    end

    logic src_tick;
    always_comb begin
        case (tmrcc_pkg::tmrcc_clk_src_t'(clock_source_select))
            tmrcc_pkg::TMRCC_CLK_NONE: src_tick = 1'b0;
            tmrcc_pkg::TMRCC_CLK_BUS: src_tick = 1'b1;
            tmrcc_pkg::TMRCC_CLK_FIXED: src_tick = fix_sync[1] && !fix_last;
            tmrcc_pkg::TMRCC_CLK_EXT:
                src_tick = ext_sync[1] && !ext_last;
            default: src_tick = 1'b0;
        endcase
    end

    wire logic cnt_wr = wr && sel_cnt;
    wire logic sc_wr = wr && sel_sc;
    wire logic tick = src_tick && ((ps_count & ps_mask(prescale_select)) ==
        ps_mask(prescale_select));

    // Prescaler after source selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_count <= '0;
        end else if (cnt_wr || sc_wr) begin
            ps_count <= '0;
        end else if (tick) begin
            ps_count <= '0;
        end else if (src_tick) begin
            ps_count <= ps_count + PS_W'(1);
        end
    end

    wire logic free_run = modulo_limit == '0 ||
        modulo_limit == CNT_W'(`TMRCC_MOD_FULL);
    wire logic [CNT_W-1:0] top = free_run ? {CNT_W{1'b1}} : modulo_limit;
    wire logic at_top = counter_value == top;
    logic wrap;
    logic turn;
    assign wrap = tick && !center_align_select && at_top;
    assign turn = tick && center_align_select &&
        dir == tmrcc_pkg::TMRCC_DIR_UP && at_top;
    wire logic ovf_event = wrap || turn;

    // Main counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value <= CNT_W'(`TMRCC_CNT_RESET);
            dir <= tmrcc_pkg::TMRCC_DIR_UP;
        end else if (cnt_wr) begin
            counter_value <= '0;
            dir <= tmrcc_pkg::TMRCC_DIR_UP;
        end else if (tick) begin
            if (!center_align_select) begin
                dir <= tmrcc_pkg::TMRCC_DIR_UP;
                counter_value <= at_top ? '0 :
                    counter_value + CNT_W'(1);
            end else if (dir == tmrcc_pkg::TMRCC_DIR_UP) begin
                if (at_top) begin
                    dir <= tmrcc_pkg::TMRCC_DIR_DOWN;
                    counter_value <= counter_value - CNT_W'(1);
                end else begin
                    counter_value <= counter_value + CNT_W'(1);
                end
            end else if (counter_value == '0) begin
                dir <= tmrcc_pkg::TMRCC_DIR_UP;
                counter_value <= CNT_W'(1);
            end else begin
                counter_value <= counter_value - CNT_W'(1);
            end
        end
    end

    // Control bits, modulo and pin control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_status_control <= `TMRCC_SC_RESET;
            modulo_limit <= CNT_W'(`TMRCC_MOD_RESET);
            pin_ctrl <= `TMRCC_CH_RESET;
        end else if (wr) begin
            if (sel_sc) begin
                timer_status_control[6:0] <= pwdata[6:0];
            end
            if (sel_mod) begin
                modulo_limit <= pwdata[CNT_W-1:0];
            end
            if (sel_ch) begin
                pin_ctrl <= pwdata[3:0];
            end
        end
    end

    // Overflow flag with read-then-write-0 clear; a new event re-arms
    wire logic flag_clear = sc_wr && clear_armed &&
        !pwdata[`TMRCC_SC_FLAG];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag <= 1'b0;
            clear_armed <= 1'b0;
        end else begin
            if (ovf_event) begin
                overflow_flag <= 1'b1;
                clear_armed <= 1'b0;
            end else if (flag_clear) begin
                overflow_flag <= 1'b0;
                clear_armed <= 1'b0;
            end else if (rd && sel_sc && overflow_flag) begin
                clear_armed <= 1'b1;
            end else if (sc_wr) begin
                clear_armed <= 1'b0;
            end
        end
    end

    // Interrupt, mode and pin ownership outputs
    wire logic owns = pin_ctrl[1:0] != 2'b00 &&
        clock_source_select != 2'b00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_irq <= 1'b0;
            center_aligned_pwm <= 1'b0;
            timer_owns_pin <= 1'b0;
            channel_pin_o <= 1'b0;
            channel_pin_oe <= 1'b0;
            channel_pin_pullup <= 1'b0;
        end else begin
            overflow_irq <= (ovf_event || (overflow_flag && !flag_clear)) &&
                overflow_irq_enable;
            center_aligned_pwm <= center_align_select;
            timer_owns_pin <= owns;
            channel_pin_o <= owns ? channel_out : gpio_out;
            channel_pin_oe <= owns ? channel_oe : gpio_oe;
            channel_pin_pullup <= owns && !channel_oe && pin_ctrl[2];
        end
    end

    // APB slave: no wait states, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) begin
                case (1'b1)
                    sel_sc: prdata <= {24'h000000, overflow_flag,
                        timer_status_control[6:0]};
                    sel_cnt: prdata <= {{(32-CNT_W){1'b0}},
                        counter_value};
                    sel_mod: prdata <= {{(32-CNT_W){1'b0}}, modulo_limit};
                    sel_ch: prdata <= {28'h0000000, pin_ctrl};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    property p_irq_gate;
        @(posedge pclk) disable iff (!presetn)
        !overflow_irq_enable |=> !overflow_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq without enable");

    property p_wrap_flag;
        @(posedge pclk) disable iff (!presetn)
        wrap |=> overflow_flag && counter_value == '0;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag)
        else $error("wrap no flag");

    property p_turn_flag;
        @(posedge pclk) disable iff (!presetn)
        turn && !cnt_wr |=>
            overflow_flag && dir == tmrcc_pkg::TMRCC_DIR_DOWN;
    endproperty
    a_turn_flag: assert property (p_turn_flag)
        else $error("turn no flag");

    property p_cnt_reset;
        @(posedge pclk) disable iff (!presetn)
        cnt_wr |=> counter_value == '0;
    endproperty
    a_cnt_reset: assert property (p_cnt_reset)
        else $error("cnt not reset");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        clock_source_select == 2'b00 && !cnt_wr |=> $stable(counter_value);
    endproperty
    a_hold: assert property (p_hold)
        else $error("count moved");

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        ovf_event && flag_clear |=> overflow_flag;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost");

    property p_w1_noeffect;
        @(posedge pclk) disable iff (!presetn)
        sc_wr && pwdata[`TMRCC_SC_FLAG] && !overflow_flag && !ovf_event
        |=> !overflow_flag;
    endproperty
    a_w1_noeffect: assert property (p_w1_noeffect)
        else $error("w1 set flag");

    property p_step;
        @(posedge pclk) disable iff (!presetn)
        tick && !center_align_select && !at_top && !cnt_wr
        |=> counter_value == $past(counter_value) + CNT_W'(1);
    endproperty
    a_step: assert property (p_step)
        else $error("bad step");

    property p_pin_gpio;
        @(posedge pclk) disable iff (!presetn)
        !owns |=> channel_pin_oe == $past(gpio_oe);
    endproperty
    a_pin_gpio: assert property (p_pin_gpio)
        else $error("pin not gpio");

    property p_irq_follow;
        @(posedge pclk) disable iff (!presetn)
        overflow_flag && overflow_irq_enable && !flag_clear |=> overflow_irq;
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("irq missing");

    property p_pin_timer;
        @(posedge pclk) disable iff (!presetn)
        owns |=> channel_pin_oe == $past(channel_oe) &&
            channel_pin_o == $past(channel_out);
    endproperty
    a_pin_timer: assert property (p_pin_timer)
        else $error("port drove owned pin");

    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held");

    c_wrap: cover property (@(posedge pclk) disable iff (!presetn) wrap);
    c_turn: cover property (@(posedge pclk) disable iff (!presetn) turn);
    c_clear: cover property (@(posedge pclk) disable iff (!presetn)
        flag_clear);
    c_ext: cover property (@(posedge pclk) disable iff (!presetn)
        tick && clock_source_select == 2'b11);
endmodule

`default_nettype wire

// File: verification/tmrcc_clk_source_model.sv
// Far-side clock sources feeding the timer core
`timescale 1ns/100ps
`default_nettype none
module tmrcc_clk_source_model (
    input wire logic ext_run,
    output logic ext_clk,
    output logic fix_clk
);
    // External pin clock: 90 ns period, below a quarter of the bus rate
    initial begin
        ext_clk = 1'b0;
        // Offset keeps pin edges away from the bus clock's rising edges
        #3;
        forever begin
            #45;
            ext_clk = ext_run ? ~ext_clk : 1'b0;
        end
    end
    // Fixed clock runs free with its own phase
    initial begin
        fix_clk = 1'b0;
        #7;
        forever begin
            #50;
            fix_clk = ~fix_clk;
        end
    end
endmodule
`default_nettype wire

// File: verification/timer_counter_core_control_test.sv
// Self-checking bench of the timer core over APB
`timescale 1ns/100ps
`default_nettype none
module timer_counter_core_control_test;
    logic pclk, presetn, psel, penable, pwrite, ext_run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v, w;
    logic pready, pslverr, err, ext_clk, fix_clk;
    logic [1:0] ms, els;
    logic ch_o, ch_oe, gp_o, gp_oe, pin_o, pin_oe, pin_pu, owns;
    logic [15:0] cnt;
    logic calign, irq;
    int fails, checked;

    tmrcc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_timer_clock_in(ext_clk), .fixed_system_clock(fix_clk),
        .channel_mode_select(ms), .channel_edge_level_select(els),
        .channel_out(ch_o), .channel_oe(ch_oe), .gpio_out(gp_o),
        .gpio_oe(gp_oe), .channel_pin_o(pin_o), .channel_pin_oe(pin_oe),
        .channel_pin_pullup(pin_pu), .timer_owns_pin(owns),
        .counter_value(cnt), .center_aligned_pwm(calign),
        .overflow_irq(irq));
    tmrcc_clk_source_model src (.ext_run(ext_run), .ext_clk(ext_clk),
        .fix_clk(fix_clk));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, exp, input string m);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask

    task automatic chk_rng(input logic [31:0] got, lo, hi, input string m);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fails++;
            $display("MISMATCH at %0t: %s got %0d", $time, m, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask

    task automatic test_reset();
        repeat (5) @(posedge pclk);
        rd(12'h000, v);
        chk(v, 32'h0000_0000, "status after reset");
        rd(12'h004, v);
        chk(v, 32'h0000_0000, "counter idle after reset");
        chk({owns, pin_oe, pin_pu, irq}, 4'h0, "pins after reset");
        apb(1'b0, 12'h010, 32'h0000_0000, v, err);
        chk(err, 1'b1, "unmapped read flags error");
        chk(v, 32'h0000_0000, "unmapped read data");
        $display("test reset done");
    endtask

    task automatic test_prescale();
        logic [31:0] e;
        for (int ps = 0; ps < 8; ps++) begin
            wr(12'h000, 32'h0000_0008 | ps);
            wr(12'h004, 32'h0000_ABCD);
            repeat (512) @(posedge pclk);
            rd(12'h004, v);
            e = 512 >> ps;
            chk_rng(v, e - 1, e + (8 >> ps) + 1, "prescaled count");
        end
        wr(12'h000, 32'h0000_0000);
        rd(12'h004, v);
        repeat (20) @(posedge pclk);
        rd(12'h004, w);
        chk(w, v, "counter holds with no clock");
        wr(12'h004, 32'h0000_1234);
        rd(12'h004, v);
        chk(v, 32'h0000_0000, "counter write clears");
        $display("test prescale done");
    endtask

    task automatic test_sources();
        els <= 2'b00;
        ext_run <= 1'b1;
        wr(12'h000, 32'h0000_0018);
        wr(12'h004, 32'h0000_0000);
        repeat (400) @(posedge pclk);
        rd(12'h004, v);
        chk_rng(v, 86, 93, "external clock count");
        ext_run <= 1'b0;
        wr(12'h000, 32'h0000_0010);
        wr(12'h004, 32'h0000_0000);
        repeat (400) @(posedge pclk);
        rd(12'h004, v);
        chk_rng(v, 77, 84, "fixed clock count");
        $display("test sources done");
    endtask

    task automatic test_overflow();
        wr(12'h008, 32'h0000_0003);
        wr(12'h004, 32'h0000_0000);
        wr(12'h000, 32'h0000_0048);
        repeat (10) @(posedge pclk);
        chk(irq, 1'b1, "irq with flag and enable");
        chk(cnt <= 16'h0003, 1'b1, "modulo bound");
        rd(12'h000, v);
        chk(v[7:0], 8'hC8, "flag set on wrap");
        wr(12'h000, 32'h0000_00C0);
        rd(12'h000, v);
        chk(v[7:0], 8'hC0, "writing one keeps flag set");
        wr(12'h000, 32'h0000_0040);
        rd(12'h000, v);
        chk({v[7:0], irq}, 9'h080, "flag cleared");
        wr(12'h000, 32'h0000_00C0);
        rd(12'h000, v);
        chk(v[7:0], 8'h40, "writing one leaves flag");
        wr(12'h000, 32'h0000_0048);
        repeat (10) @(posedge pclk);
        rd(12'h000, v);
        repeat (8) @(posedge pclk);
        wr(12'h000, 32'h0000_0040);
        rd(12'h000, v);
        chk(v[7], 1'b1, "new overflow keeps flag");
        wr(12'h000, 32'h0000_0080);
        repeat (3) @(posedge pclk);
        chk({irq, calign}, 2'b00, "no irq when disabled");
        $display("test overflow done");
    endtask

    task automatic test_center();
        logic [15:0] prev;
        int over, down;
        over = 0;
        down = 0;
        rd(12'h000, v);
        wr(12'h000, 32'h0000_0000);
        wr(12'h004, 32'h0000_0000);
        rd(12'h000, v);
        chk(v[7], 1'b0, "flag cleared before center");
        wr(12'h000, 32'h0000_0028);
        prev = cnt;
        repeat (40) begin
            @(negedge pclk);
            if (cnt > 16'h0003) over++;
            if (cnt < prev) down++;
            prev = cnt;
        end
        chk(calign, 1'b1, "center select output");
        chk(over, 0, "center count bounded");
        chk(down > 0, 1'b1, "center count turns down");
        rd(12'h000, v);
        chk(v[7], 1'b1, "flag set on turn");
        wr(12'h000, 32'h0000_0000);
        $display("test center done");
    endtask

    task automatic test_pin();
        els <= 2'b01;
        ms <= 2'b01;
        ch_o <= 1'b1;
        ch_oe <= 1'b1;
        gp_o <= 1'b0;
        gp_oe <= 1'b0;
        wr(12'h00C, 32'h0000_0001);
        wr(12'h000, 32'h0000_0008);
        repeat (3) @(posedge pclk);
        chk({owns, pin_o, pin_oe}, 3'b111, "timer drives pin");
        ch_oe <= 1'b0;
        gp_oe <= 1'b1;
        wr(12'h00C, 32'h0000_0005);
        repeat (3) @(posedge pclk);
        chk({owns, pin_pu, pin_oe}, 3'b110, "pull-up on timer input");
        wr(12'h00C, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        chk({owns, pin_o, pin_oe}, 3'b001, "pin back to port");
        wr(12'h000, 32'h0000_0000);
        $display("test pin done");
    endtask

    task automatic report_and_stop();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        fails = 0;
        checked = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, ext_run} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        {ms, els} = 4'h0;
        {ch_o, ch_oe, gp_o, gp_oe} = 4'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_prescale();
        test_sources();
        test_overflow();
        test_center();
        test_pin();
        report_and_stop();
    end

    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule
`default_nettype wire
